// ### bench/dcsa_host_model.sv
`default_nettype none

module dcsa_host_model
    import dcsa_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Controller events
    input wire logic rw_start_pulse,
    input wire logic seek_io_pulse,
    input wire logic done_clear,
    input wire dcsa_cmd_t cmd_in,
    // Cable to the adapter
    output dcsa_host_t host
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host <= '0;
        end else begin
            if (rw_start_pulse || seek_io_pulse) begin
                host.start <= 1'b1;
            end else if (done_clear) begin
                host.start <= 1'b0;
            end
            // Idle cable toggles so a stale value cannot pass for live data
            host.sig <= host.start ? cmd_in : ~host.sig;
        end
    end
endmodule

`default_nettype wire

// ### bench/tb_dual_controller_select_arbiter.sv
`default_nettype none

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
    $display("CHECK FAILED t=%0t line %0d", $time, `__LINE__); end end

module tb_dual_controller_select_arbiter
    import dcsa_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata_ff, rd;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    logic [1:0] rw_p = '0, seek_p = '0, clr = '0;
    dcsa_cmd_t cmd_a = '0, cmd_b = '0, adapter_cmd_ff;
    dcsa_host_t host_a, host_b;
    dcsa_cond_t cond = '0;
    dcsa_stat_t adapter_stat = '0, host_a_stat_ff, host_b_stat_ff;
    logic hready, hresp_ff, grant_a_ff, grant_b_ff, arb_idle_ff, transfer_complete_ff;
    logic grant_clear_ff, irq_ff;
    int err_count = 0, cmp_count = 0, owner = 0, exp_int = 0, n;
    int exp_q[$];

    always #5 hclk = ~hclk;

    dcsa_arbiter #(.WDOG_CYCLES(200)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout_ff(hready), .hresp_ff(hresp_ff), .hrdata_ff(hrdata_ff),
        .host_a(host_a), .host_b(host_b), .host_a_stat_ff(host_a_stat_ff),
        .host_b_stat_ff(host_b_stat_ff), .cond(cond), .adapter_stat(adapter_stat),
        .adapter_cmd_ff(adapter_cmd_ff), .grant_a_ff(grant_a_ff), .grant_b_ff(grant_b_ff),
        .arb_idle_ff(arb_idle_ff), .transfer_complete_ff(transfer_complete_ff),
        .grant_clear_ff(grant_clear_ff), .irq_ff(irq_ff));
    dcsa_host_model i_host_a (.hclk(hclk), .hresetn(hresetn), .rw_start_pulse(rw_p[0]),
        .seek_io_pulse(seek_p[0]), .done_clear(clr[0]), .cmd_in(cmd_a), .host(host_a));
    dcsa_host_model i_host_b (.hclk(hclk), .hresetn(hresetn), .rw_start_pulse(rw_p[1]),
        .seek_io_pulse(seek_p[1]), .done_clear(clr[1]), .cmd_in(cmd_b), .host(host_b));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One phase of a transfer; r samples hready at the falling edge before the closing edge
    task automatic ahb_phase();
        logic r;
        r = 0;
        for (int i = 0; i < 50 && !r; i++) begin
            @(negedge hclk);
            r = hready;
            rd = hrdata_ff;
            @(posedge hclk);
        end
        if (!r) begin
            err_count++;
            print_verdict();
        end
    endtask

    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0_0000, a};
        hwrite <= w;
        ahb_phase();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        ahb_phase();
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, '0);
        `CHK(rd, e)
        `CHK(hresp_ff, 1'b0)
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return grant_a_ff;
            1: return grant_b_ff;
            2: return arb_idle_ff;
            3: return grant_clear_ff;
            default: return irq_ff;
        endcase
    endfunction

    task automatic wait_sig(input int s, input logic v, input int lim);
        for (n = 0; n < lim; n++) begin
            @(negedge hclk);
            if (pick(s) === v) break;
        end
        @(posedge hclk);
        if (n == lim) begin
            err_count++;
            print_verdict();
        end
    endtask

    // Port p raises start through a read/write start or a seek pulse
    task automatic kick(input int p, input logic seek);
        cmd_a <= dcsa_cmd_t'($urandom);
        cmd_b <= dcsa_cmd_t'($urandom);
        if (seek) seek_p[p] <= 1'b1;
        else rw_p[p] <= 1'b1;
        @(posedge hclk);
        seek_p <= '0;
        rw_p <= '0;
    endtask

    // Grant of port p lands; model tracks owner and expected events
    task automatic granted(input int p);
        wait_sig(p, 1'b1, 40);
        owner = p + 1;
        exp_q.push_back(p);
        @(posedge hclk);
        @(posedge hclk);
        `CHK(pick(1 - p), 1'b0)
        `CHK(arb_idle_ff, 1'b0)
        `CHK(adapter_cmd_ff, (p == 0) ? cmd_a : cmd_b)
        `CHK((p == 0) ? host_a_stat_ff : host_b_stat_ff, adapter_stat)
        rchk(STATUS_OFS, {26'h0, 1'b0, (p == 0) ? 5'h09 : 5'h12});
    endtask

    // Release of the grant of port p after a completion or fault
    task automatic released(input int p);
        wait_sig(2, 1'b1, 300);
        `CHK(grant_a_ff | grant_b_ff, 1'b0)
        `CHK(transfer_complete_ff, 1'b1)
        cond <= '0;
        clr[p] <= 1'b1;
        @(posedge hclk);
        clr <= '0;
        owner = 0;
        wait_sig(3, 1'b0, 400);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(16));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(CTRL_OFS, 32'h0000_0003);
        rchk(INT_MASK_OFS, 32'h0000_0000);
        rchk(INT_STAT_OFS, 32'h0000_0000);
        ahb(1'b1, 12'h010, 32'hFFFF_FFFF);
        rchk(12'h010, 32'h0000_0000);
        ahb(1'b1, INT_MASK_OFS, 32'h0000_000F);
        $display("test registers done");

        adapter_stat <= dcsa_stat_t'($urandom);
        kick(0, 1'b0);
        granted(0);
        `CHK(host_a_stat_ff, adapter_stat)
        `CHK(host_b_stat_ff, 4'h0)
        `CHK(irq_ff, 1'b1)
        kick(1, 1'b1);
        repeat (30) @(posedge hclk);
        `CHK(grant_b_ff, 1'b0)
        kick(0, 1'b1);
        repeat (30) @(posedge hclk);
        `CHK(grant_a_ff, 1'b1)
        cond.transfer_finished <= 1'b1;
        cond.stop_set <= 1'b1;
        released(0);
        granted(1);
        exp_int = 32'h0000_000B;
        rchk(INT_STAT_OFS, exp_int);
        ahb(1'b1, INT_STAT_OFS, 32'h0000_000F);
        rchk(INT_STAT_OFS, 32'h0000_0000);
        `CHK(irq_ff, 1'b0)
        cond.end_of_cylinder <= 1'b1;
        released(1);
        $display("test grant and release done");

        for (int i = 0; i < 3; i++) begin
            kick(i % 2, 1'b1);
            granted(i % 2);
            if (i == 0) cond.address_or_unsafe_fault <= 1'b1;
            else if (i == 1) cond.checkword_error <= 1'b1;
            else cond.power_clear <= 1'b1;
            if (i == 2) begin
                wait_sig(3, 1'b1, 10);
                @(posedge hclk);
                `CHK(grant_a_ff, 1'b0)
            end
            released(i % 2);
        end
        $display("test faults done");

        ahb(1'b1, INT_MASK_OFS, 32'h0000_0000);
        ahb(1'b1, INT_STAT_OFS, 32'h0000_000F);
        kick(1, 1'b0);
        wait_sig(1, 1'b1, 40);
        wait_sig(2, 1'b1, 400);
        `CHK(n >= 198 && n <= 206, 1'b1)
        `CHK(irq_ff, 1'b0)
        ahb(1'b1, INT_MASK_OFS, 32'h0000_0004);
        wait_sig(4, 1'b1, 5);
        clr[1] <= 1'b1;
        @(posedge hclk);
        clr <= '0;
        wait_sig(3, 1'b0, 400);
        ahb(1'b1, INT_STAT_OFS, 32'h0000_000F);
        wait_sig(4, 1'b0, 5);
        $display("test watchdog done");

        ahb(1'b1, CTRL_OFS, 32'h0000_0002);
        kick(0, 1'b0);
        repeat (40) @(posedge hclk);
        `CHK(grant_a_ff, 1'b0)
        ahb(1'b1, CTRL_OFS, 32'h0000_0003);
        granted(0);
        `CHK(exp_q.size(), 6)
        $display("test port enable done");
        print_verdict();
    end
endmodule

`undef CHK

`default_nettype wire

// ### verilog/dcsa_arbiter.sv
// What this block does
// - Two-stage Johnson ring counter on hclk gives four repeating phases.
// - Port A grant sampled at phase two, port B grant at phase four.
// - Port A granted only if its start request is high at phase two.
// - Port B granted only if its start request is high at phase four.
// - The two grants are never set together.
// - Any grant drops the idle line and halts the ring counter.
// - Idle falling starts the watchdog; expiry fires a clear pulse dropping grants.
// - Transfer complete cancels the watchdog and fires the clear pulse.
// - Transfer complete sets when a transfer finishes with stop set.
// - Halt conditions or power clear set transfer complete at once.
// - Power clear asserts grant clear directly.
// - Seek completion does not release the grant.
// - After release the counter keeps running so either port may be regranted.
// - Only the granted port's signals reach the adapter logic.
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`default_nettype none

module dcsa_arbiter
    import dcsa_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = WDOG_CYC_DFLT
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout_ff,
    output logic hresp_ff,
    output logic [31:0] hrdata_ff,
    // Host ports
    input wire dcsa_host_t host_a,
    input wire dcsa_host_t host_b,
    output dcsa_stat_t host_a_stat_ff,
    output dcsa_stat_t host_b_stat_ff,
    // Adapter logic side
    input wire dcsa_cond_t cond,
    input wire dcsa_stat_t adapter_stat,
    output dcsa_cmd_t adapter_cmd_ff,
    // Arbiter state
    output logic grant_a_ff,
    output logic grant_b_ff,
    output logic arb_idle_ff,
    output logic transfer_complete_ff,
    output logic grant_clear_ff,
    output logic irq_ff
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    dcsa_host_t host_a_meta_ff, host_a_s_ff;
    dcsa_host_t host_b_meta_ff, host_b_s_ff;
    dcsa_cond_t cond_meta_ff, cond_s_ff;
    dcsa_stat_t stat_meta_ff, stat_s_ff;

    // Pins come from other clock domains; meta stage feeds only sync stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_a_meta_ff <= '0;
            host_a_s_ff <= '0;
            host_b_meta_ff <= '0;
            host_b_s_ff <= '0;
            cond_meta_ff <= '0;
            cond_s_ff <= '0;
            stat_meta_ff <= '0;
            stat_s_ff <= '0;
        end else begin
            host_a_meta_ff <= host_a;
            host_a_s_ff <= host_a_meta_ff;
            host_b_meta_ff <= host_b;
            host_b_s_ff <= host_b_meta_ff;
            cond_meta_ff <= cond;
            cond_s_ff <= cond_meta_ff;
            stat_meta_ff <= adapter_stat;
            stat_s_ff <= stat_meta_ff;
        end
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [1:0] ctrl_ff;
    logic [3:0] int_stat_ff;
    logic [3:0] int_mask_ff;
    logic [1:0] ring_ff;
    logic timeout;
    logic [3:0] events;

    function automatic logic [31:0] read_mux(input logic [11:0] ofs);
        logic [31:0] val;
        val = 32'h0000_0000;
        case (ofs)
            CTRL_OFS: val = {30'h0000_0000, ctrl_ff};
            STATUS_OFS: val = {26'h000_0000, transfer_complete_ff, ring_ff,
                               arb_idle_ff, grant_b_ff, grant_a_ff};
            INT_STAT_OFS: val = {28'h000_0000, int_stat_ff};
            INT_MASK_OFS: val = {28'h000_0000, int_mask_ff};
            default: val = 32'h0000_0000;
        endcase
        return val;
    endfunction

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    logic addr_take;
    logic wr_pend_ff;
    logic [11:0] wr_ofs_ff;

    assign addr_take = hsel && htrans[1] && hready;

    // Zero wait states, OKAY always; unmapped reads return zero, writes drop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            hrdata_ff <= 32'h0000_0000;
            wr_pend_ff <= 1'b0;
            wr_ofs_ff <= 12'h000;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            wr_pend_ff <= addr_take && hwrite && haddr[31:12] == 20'h0_0000;
            wr_ofs_ff <= haddr[11:0];
            if (addr_take && !hwrite && haddr[31:12] == 20'h0_0000) begin
                hrdata_ff <= read_mux(haddr[11:0]);
            end else begin
                hrdata_ff <= 32'h0000_0000;
            end
        end
    end

    logic wr_ctrl, wr_stat, wr_mask;
    assign wr_ctrl = wr_pend_ff && wr_ofs_ff == CTRL_OFS;
    assign wr_stat = wr_pend_ff && wr_ofs_ff == INT_STAT_OFS;
    assign wr_mask = wr_pend_ff && wr_ofs_ff == INT_MASK_OFS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= CTRL_RST;
            int_mask_ff <= INT_MASK_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= hwdata[1:0];
            end
            if (wr_mask) begin
                int_mask_ff <= hwdata[3:0];
            end
        end
    end

    // Set wins over write-one-to-clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_stat_ff <= 4'h0;
        end else if (wr_stat) begin
            int_stat_ff <= (int_stat_ff & ~hwdata[3:0]) | events;
        end else begin
            int_stat_ff <= int_stat_ff | events;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(int_stat_ff & int_mask_ff);
        end
    end

    // ----------------------------------------
    // Ring counter and grants
    // ----------------------------------------
    logic [1:0] nxt_ring;
    logic nxt_grant_a, nxt_grant_b;
    logic running;

    assign running = !(grant_a_ff || grant_b_ff);
    // Johnson sequence 00 01 11 10
    assign nxt_ring = running ? {ring_ff[0], ~ring_ff[1]} : ring_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ring_ff <= RING_RESET;
        end else begin
            ring_ff <= nxt_ring;
        end
    end

    always_comb begin
        nxt_grant_a = grant_a_ff;
        nxt_grant_b = grant_b_ff;
        if (grant_clear_ff) begin
            nxt_grant_a = 1'b0;
            nxt_grant_b = 1'b0;
        end else if (running) begin
            // halt after one grant keeps them exclusive
            if (nxt_ring == RING_PH2) begin
                nxt_grant_a = host_a_s_ff.start && ctrl_ff[CTRL_EN_A_BIT];
            end
            if (nxt_ring == RING_PH4) begin
                nxt_grant_b = host_b_s_ff.start && ctrl_ff[CTRL_EN_B_BIT];
            end
        end
    end

    // only clear releases a grant, never seek completion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            grant_a_ff <= 1'b0;
            grant_b_ff <= 1'b0;
            arb_idle_ff <= 1'b1;
        end else begin
            grant_a_ff <= nxt_grant_a;
            grant_b_ff <= nxt_grant_b;
            arb_idle_ff <= !(nxt_grant_a || nxt_grant_b);
        end
    end

    // ----------------------------------------
    // Transfer complete
    // ----------------------------------------
    logic halt;
    assign halt = cond_s_ff.end_of_cylinder || cond_s_ff.address_or_unsafe_fault
               || cond_s_ff.checkword_error || cond_s_ff.power_clear;

    // halt or power clear at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transfer_complete_ff <= 1'b0;
        end else begin
            transfer_complete_ff <= (cond_s_ff.transfer_finished && cond_s_ff.stop_set) || halt;
        end
    end

    // ----------------------------------------
    // Watchdog and clear pulse
    // ----------------------------------------
    // idle falling edge starts watch
    dcsa_watchdog #(
        .WDOG_CYCLES(WDOG_CYCLES)
    ) u_watchdog (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(arb_idle_ff && (nxt_grant_a || nxt_grant_b)),
        .cancel(transfer_complete_ff),
        .power_clear(cond_s_ff.power_clear),
        .grant_clear_ff(grant_clear_ff),
        .timeout_ff(timeout)
    );

    always_comb begin
        events = 4'h0;
        events[EV_GRANT_A_BIT] = nxt_grant_a && !grant_a_ff;
        events[EV_GRANT_B_BIT] = nxt_grant_b && !grant_b_ff;
        events[EV_TIMEOUT_BIT] = timeout;
        events[EV_RELEASE_BIT] = !arb_idle_ff && !(nxt_grant_a || nxt_grant_b);
    end

    // ----------------------------------------
    // Signal routing
    // ----------------------------------------
    // only the granted port passes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adapter_cmd_ff <= '0;
            host_a_stat_ff <= '0;
            host_b_stat_ff <= '0;
        end else begin
            if (grant_a_ff) begin
                adapter_cmd_ff <= host_a_s_ff.sig;
            end else if (grant_b_ff) begin
                adapter_cmd_ff <= host_b_s_ff.sig;
            end else begin
                adapter_cmd_ff <= '0;
            end
            host_a_stat_ff <= grant_a_ff ? stat_s_ff : '0;
            host_b_stat_ff <= grant_b_ff ? stat_s_ff : '0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_grant_exclusive: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !(grant_a_ff && grant_b_ff)
    ) else $error("both grants set");

    a_ring_halts: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (grant_a_ff || grant_b_ff) |=> ring_ff == $past(ring_ff)
    ) else $error("ring counter moved while granted");

    a_idle_tracks: assert property (
        @(posedge hclk) disable iff (!hresetn)
        arb_idle_ff == !(grant_a_ff || grant_b_ff)
    ) else $error("idle line disagrees with grants");

    a_grant_a_phase: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(grant_a_ff) |-> ring_ff == RING_PH2 && $past(host_a_s_ff.start)
    ) else $error("port A granted off phase or without start");

    a_grant_b_phase: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(grant_b_ff) |-> ring_ff == RING_PH4 && $past(host_b_s_ff.start)
    ) else $error("port B granted off phase or without start");

    a_clear_drops: assert property (
        @(posedge hclk) disable iff (!hresetn)
        grant_clear_ff |=> !grant_a_ff && !grant_b_ff
    ) else $error("grant survived clear");

    a_done_clears: assert property (
        @(posedge hclk) disable iff (!hresetn)
        transfer_complete_ff |=> grant_clear_ff ##1 !grant_a_ff && !grant_b_ff
    ) else $error("transfer complete did not release");

    a_halt_completes: assert property (
        @(posedge hclk) disable iff (!hresetn)
        halt |=> transfer_complete_ff
    ) else $error("halt did not set transfer complete");

    a_finish_completes: assert property (
        @(posedge hclk) disable iff (!hresetn)
        cond_s_ff.transfer_finished && cond_s_ff.stop_set |=> transfer_complete_ff
    ) else $error("finish with stop did not complete");

    a_route_port_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        grant_a_ff |=> adapter_cmd_ff == $past(host_a_s_ff.sig)
    ) else $error("port A signals not routed");

    a_irq_level: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ##1 irq_ff == $past(|(int_stat_ff & int_mask_ff))
    ) else $error("interrupt level wrong");

endmodule

`default_nettype wire

// ### verilog/dcsa_pkg.sv
`default_nettype none

package dcsa_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned WDOG_TIME_S = 6;
    // Longest time: rounded down
    localparam int unsigned WDOG_CYC_DFLT = WDOG_TIME_S * CLK_HZ;
    localparam int unsigned CLR_PULSE_NS = 1600;
    // Least time: rounded up
    localparam int unsigned CLR_PULSE_CYC = (CLR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WDOG_CNT_W = 30;

    // ----------------------------------------
    // Ring counter codes (two-stage Johnson)
    // ----------------------------------------
    localparam logic [1:0] RING_RESET = 2'h0;
    localparam logic [1:0] RING_PH2 = 2'h1;
    localparam logic [1:0] RING_PH4 = 2'h2;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] INT_STAT_OFS = 12'h008;
    localparam logic [11:0] INT_MASK_OFS = 12'h00C;
    localparam logic [1:0] CTRL_RST = 2'h3;
    localparam logic [3:0] INT_MASK_RST = 4'h0;
    localparam int unsigned CTRL_EN_A_BIT = 0;
    localparam int unsigned CTRL_EN_B_BIT = 1;
    localparam int unsigned EV_GRANT_A_BIT = 0;
    localparam int unsigned EV_GRANT_B_BIT = 1;
    localparam int unsigned EV_TIMEOUT_BIT = 2;
    localparam int unsigned EV_RELEASE_BIT = 3;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] cmd;
        logic ctrl;
        logic [7:0] data;
    } dcsa_cmd_t;

    typedef struct packed {
        logic start;
        dcsa_cmd_t sig;
    } dcsa_host_t;

    typedef struct packed {
        logic transfer_finished;
        logic stop_set;
        logic end_of_cylinder;
        logic address_or_unsafe_fault;
        logic checkword_error;
        logic power_clear;
    } dcsa_cond_t;

    typedef logic [3:0] dcsa_stat_t;

endpackage

`default_nettype wire

// ### verilog/dcsa_watchdog.sv
`default_nettype none

module dcsa_watchdog
    import dcsa_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = WDOG_CYC_DFLT
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic start,
    input wire logic cancel,
    input wire logic power_clear,
    // Results
    output logic grant_clear_ff,
    output logic timeout_ff
);

    typedef enum logic [1:0] {WD_IDLE, WD_WATCH, WD_PULSE} dcsa_wd_t;

    dcsa_wd_t state_ff;
    dcsa_wd_t nxt_state;
    logic [WDOG_CNT_W-1:0] cnt_ff;
    logic expire;

    assign expire = (cnt_ff == WDOG_CNT_W'(WDOG_CYCLES - 1));

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            WD_IDLE: begin
                if (cancel) begin
                    nxt_state = WD_PULSE;
                end else if (start) begin
                    nxt_state = WD_WATCH;
                end
            end
            WD_WATCH: begin
                if (cancel || expire) begin
                    nxt_state = WD_PULSE;
                end
            end
            WD_PULSE: begin
                if (cancel) begin
                    nxt_state = WD_PULSE;
                end else if (cnt_ff == WDOG_CNT_W'(CLR_PULSE_CYC - 1)) begin
                    nxt_state = WD_IDLE;
                end
            end
            default: nxt_state = WD_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= WD_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= '0;
        end else if (nxt_state != state_ff || (state_ff == WD_PULSE && cancel)) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + WDOG_CNT_W'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            grant_clear_ff <= 1'b0;
            timeout_ff <= 1'b0;
        end else begin
            grant_clear_ff <= power_clear || (nxt_state == WD_PULSE);
            timeout_ff <= (state_ff == WD_WATCH) && expire && !cancel;
        end
    end

    a_timeout_pulse: assert property (
        @(posedge hclk) disable iff (!hresetn)
        timeout_ff |-> grant_clear_ff
    ) else $error("timeout did not start clear pulse");

    a_pulse_length: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(grant_clear_ff) |-> $past(cnt_ff) == WDOG_CNT_W'(CLR_PULSE_CYC - 1)
    ) else $error("clear pulse length wrong");

endmodule

`default_nettype wire
